// File: testbench/program_sequencer_chk.sv
// Purpose: port-level checks on the program sequencer
// Assumes: an op counts only at an edge with seq_ready high
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
module program_sequencer_chk
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // decoder side
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic op_len_two,
  input wire logic [11:0] target,
  input wire logic branch_taken,
  input wire logic [3:0] pointer_low,
  input wire logic [3:0] pointer_high,
  // outputs watched
  input wire logic [13:0] rom_addr,
  input wire logic [11:0] pc,
  input wire logic rom_bank_sel_lo,
  input wire logic rom_bank_sel_hi,
  input wire logic seq_ready,
  input wire logic timer_ack,
  input wire logic rtc_ack,
  input wire logic carry_load
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // accepted op, ignored ones must not move the counter
  logic take;
  assign take = op_valid && seq_ready;
  reset_clr_a: assert property ($past(rst) |->
    pc == 12'h000 && !rom_bank_sel_lo && !rom_bank_sel_hi)
    else $error("counter or bank not clear after reset");
  seq_step_a: assert property (take && op_code == 4'h0 |=>
    pc == $past(pc) + {10'h000, $past(op_len_two), !$past(op_len_two)})
    else $error("sequential step wrong");
  jump_load_a: assert property (take && op_code inside {1, 2} |=>
    pc == $past(target)) else $error("jump target not loaded");
  branch_keep_a: assert property (take && op_code == 4'h3 && branch_taken
    |=> pc == ($past(pc) & 12'h800 | $past(target) & 12'h7FF))
    else $error("branch load wrong");
  bank_map_a: assert property (seq_ready |->
    rom_addr == {rom_bank_sel_hi, rom_bank_sel_lo, pc})
    else $error("fetch address not bank and counter");
  rtc_vec_a: assert property (rtc_ack |-> pc == 12'h008)
    else $error("rtc vector wrong");
  timer_vec_a: assert property (timer_ack |-> pc == 12'h004)
    else $error("timer vector wrong");
  interrupt_return_op_carry_a: assert property (take && op_code == 4'h5 |=>
    carry_load) else $error("carry not restored");
  table_page_a: assert property (take && op_code inside {6, 7} |=>
    rom_addr[11:0] == {pc[11:8], $past(pointer_high), $past(pointer_low)})
    else $error("table address wrong");
endmodule // program_sequencer_chk
bind program_sequencer program_sequencer_chk chk_u (.*);

// File: testbench/program_sequencer_tb_top.sv
// Purpose: directed self-checking bench for the program sequencer
// Assumes: inputs change on the falling edge of sys_clk
// Notes: rom_model answers fetches; ops leave an idle edge between them
`timescale 1ns/1ps
module program_sequencer_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, op_len_two = 1'b0;
  logic branch_taken = 1'b0, bank_wr = 1'b0, carry_in = 1'b0;
  logic int_enable = 1'b0, int_disable = 1'b0;
  logic timer_pend = 1'b0, rtc_pend = 1'b0;
  logic [3:0] op_code = 4'h0, pointer_low = 4'hA, pointer_high = 4'h5;
  logic [11:0] target = 12'h000, pc;
  logic [1:0] bank_wdata = 2'h0;
  logic [13:0] rom_addr, taddr;
  logic [7:0] rom_data, table_byte;
  logic rom_bank_sel_lo, rom_bank_sel_hi, seq_ready, timer_ack, rtc_ack;
  logic carry_load, carry_value, table_to_reg, table_to_mem;
  int fails = 0, checks_done = 0, cycles = 0;
  program_sequencer dut_u (.*);
  rom_model rom_u (.*);
  // 8 ns clock
  always #4 sys_clk = ~sys_clk;
  // hang guard, far beyond the fewer than a hundred cycles used
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      give_verdict;
    end
  end
  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one op, held for a single edge once the sequencer is ready
  task automatic op(logic [3:0] c, logic [11:0] t, logic l2, logic bt);
    @(negedge sys_clk);
    for (int i = 0; i < 10 && seq_ready !== 1'b1; i++)
      @(negedge sys_clk);
    op_code = c;
    target = t;
    op_len_two = l2;
    branch_taken = bt;
    op_valid = 1'b1;
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask
  // acks are one-cycle pulses, so poll every cycle
  task automatic wait_ack;
    for (int i = 0; i < 8 && !(rtc_ack | timer_ack); i++)
      @(negedge sys_clk);
  endtask
  task automatic t_flow;
    check("pc", pc, 12'h000);
    check("bank", {rom_bank_sel_hi, rom_bank_sel_lo}, 2'h0);
    op(4'h1, 12'hFFE, 1'b0, 1'b0);
    check("jump", pc, 12'hFFE);
    op(4'h0, 12'h000, 1'b1, 1'b0);
    check("wrap", pc, 12'h000);
    op(4'h1, 12'h800, 1'b0, 1'b0);
    op(4'h3, 12'h123, 1'b0, 1'b1);
    check("branch", pc, 12'h923);
    bank_wdata = 2'h2;
    bank_wr = 1'b1;
    @(negedge sys_clk);
    bank_wr = 1'b0;
    @(negedge sys_clk);
    check("bank addr", rom_addr, 14'h2923);
    $display("flow done");
  endtask
  task automatic t_call;
    op(4'h1, 12'h3F0, 1'b0, 1'b0);
    op(4'h2, 12'h600, 1'b0, 1'b0);
    op(4'h2, 12'h700, 1'b0, 1'b0);
    op(4'h4, 12'h000, 1'b0, 1'b0);
    check("ret", pc, 12'h601);
    check("ret carry", carry_load, 1'b0);
    $display("call done");
  endtask
  task automatic t_irq;
    rtc_pend = 1'b1;
    timer_pend = 1'b1;
    int_enable = 1'b1;
    int_disable = 1'b1;
    @(negedge sys_clk);
    int_enable = 1'b0;
    int_disable = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("off", pc, 12'h601);
    carry_in = 1'b1;
    op(4'h2, 12'h200, 1'b0, 1'b0);
    int_enable = 1'b1;
    @(negedge sys_clk);
    int_enable = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("held", pc, 12'h200);
    op(4'h4, 12'h000, 1'b0, 1'b0);
    wait_ack;
    check("rtc first", {rtc_ack, timer_ack}, 2'h2);
    check("rtc vec", rom_addr, 14'h2008);
    rtc_pend = 1'b0;
    carry_in = 1'b0;
    op(4'h5, 12'h000, 1'b0, 1'b0);
    check("interrupt_return_op", pc, 12'h602);
    check("interrupt_return_op carry", {carry_load, carry_value}, 2'h3);
    wait_ack;
    check("timer vec", rom_addr, 14'h2004);
    timer_pend = 1'b0;
    $display("irq done");
  endtask
  task automatic t_table;
    op(4'h1, 12'h3FF, 1'b0, 1'b0);
    for (int c = 6; c < 10; c++)
    begin
      op(c[3:0], 12'h000, 1'b0, 1'b0);
      taddr = {2'h2, (c < 8) ? 4'h4 : 4'hF, 8'h5A};
      check("taddr", rom_addr, taddr);
      for (int i = 0; i < 6 && !(table_to_reg | table_to_mem); i++)
        @(negedge sys_clk);
      check("tbyte", table_byte, taddr[7:0] ^ taddr[13:6]);
      check("tdest", {table_to_reg, table_to_mem}, c[0] ? 2'h1 : 2'h2);
    end
    $display("table done");
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    t_flow;
    t_call;
    t_irq;
    t_table;
    give_verdict;
  end
endmodule // program_sequencer_tb_top

// File: testbench/rom_model.sv
// Purpose: program rom stand-in on the fetch port
// Assumes: the byte follows its address by one cycle
// Notes: contents mix address bits so a wrong page or bank shows
`timescale 1ns/1ps
module rom_model
(
  // clock
  input wire logic sys_clk,
  // fetch side
  input wire logic [13:0] rom_addr,
  output logic [7:0] rom_data
);
  // registered read; never kinder than one cycle late
  always_ff @(posedge sys_clk)
  begin
    rom_data <= rom_addr[7:0] ^ rom_addr[13:6];
  end
endmodule // rom_model

// File: verilog/irq_select.sv
// Purpose: picks which pending interrupt is acknowledged
// Assumes: pending flags are held by their sources until acknowledged
// Notes: purely combinational priority choice
`timescale 1ns/1ps
module irq_select
(
  // request side
  input wire logic timer_pend,
  input wire logic rtc_pend,
  input wire logic allowed,
  // choice
  output logic take_timer,
  output logic take_rtc
);
  // rtc wins a tie so the real-time tick is never starved
  always_comb
  begin
    take_rtc = allowed && rtc_pend;
    take_timer = allowed && timer_pend && !rtc_pend;
  end
endmodule // irq_select

// File: verilog/program_sequencer.sv
// Purpose: program counter, bank select, vectors, table reads and stack
// Assumes: rom answers one cycle after the address is presented, and
//   interrupt pending flags stand until their acknowledge pulse
// Notes: decoder issues one flow op per instruction with op_valid;
//   interrupt entry counts as a call, so a further request waits for
//   the return instead of overwriting the single stack entry
`timescale 1ns/1ps
module program_sequencer
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // decoder request
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic op_len_two,
  input wire logic [seq_pkg::PC_W-1:0] target,
  input wire logic branch_taken,
  input wire logic bank_wr,
  input wire logic [seq_pkg::BANK_W-1:0] bank_wdata,
  input wire logic int_enable,
  input wire logic int_disable,
  // table pointer and carry from the core
  input wire logic [3:0] pointer_low,
  input wire logic [3:0] pointer_high,
  input wire logic carry_in,
  // interrupt requests
  input wire logic timer_pend,
  input wire logic rtc_pend,
  // rom
  input wire logic [7:0] rom_data,
  // rom address and state
  output logic [seq_pkg::ROM_ADDR_W-1:0] rom_addr,
  output logic [seq_pkg::PC_W-1:0] pc,
  output logic rom_bank_sel_lo,
  output logic rom_bank_sel_hi,
  output logic seq_ready,
  // interrupt acknowledge
  output logic timer_ack,
  output logic rtc_ack,
  // carry restore
  output logic carry_load,
  output logic carry_value,
  // table read result
  output logic [7:0] table_byte,
  output logic table_to_reg,
  output logic table_to_mem
);
  // sequencing state
  seq_pkg::seq_state_e state;
  seq_pkg::seq_state_e next_state;
  logic [seq_pkg::PC_W-1:0] next_pc;
  logic [seq_pkg::PC_W-1:0] seq_pc;
  logic next_bank_hi;
  logic next_bank_lo;
  // stack and interrupt wiring
  logic [seq_pkg::STACK_W-1:0] stack_entry;
  logic in_call;
  logic ints_on;
  logic take_timer;
  logic take_rtc;
  logic push;
  logic push_carry_en;
  logic [seq_pkg::PC_W-1:0] push_addr;
  // table read decode
  logic tread;
  logic tread_last;
  logic tread_mem;
  logic [seq_pkg::PC_W-1:0] table_addr;
  logic is_op;
  logic take_irq;

  // compose a full rom address from bank bits and a counter value
  function automatic logic [seq_pkg::ROM_ADDR_W-1:0] rom_of(
    input logic hi, input logic lo, input logic [seq_pkg::PC_W-1:0] a);
    rom_of = {hi, lo, a};
  endfunction

  // sequential successor; the add wraps inside the 12-bit field
  function automatic logic [seq_pkg::PC_W-1:0] step_of(
    input logic [seq_pkg::PC_W-1:0] a, input logic two);
    step_of = a + (two ? 12'h002 : 12'h001);
  endfunction

  // op decode; an op counts only at an edge where the sequencer is ready
  assign is_op = op_valid && seq_ready && state == seq_pkg::ST_FETCH;
  assign tread = is_op && (op_code == seq_pkg::OP_TREAD_REG ||
    op_code == seq_pkg::OP_TREAD_MEM ||
    op_code == seq_pkg::OP_TREAD_LAST_REG ||
    op_code == seq_pkg::OP_TREAD_LAST_MEM);
  assign tread_last = op_code == seq_pkg::OP_TREAD_LAST_REG ||
    op_code == seq_pkg::OP_TREAD_LAST_MEM;
  assign tread_mem = op_code == seq_pkg::OP_TREAD_MEM ||
    op_code == seq_pkg::OP_TREAD_LAST_MEM;
  assign take_irq = (take_timer || take_rtc) && state == seq_pkg::ST_FETCH
    && !is_op;

  // priority choice between the two pending requests
  irq_select u_irq
  (
    .timer_pend(timer_pend),
    .rtc_pend(rtc_pend),
    .allowed(ints_on && !in_call),
    .take_timer(take_timer),
    .take_rtc(take_rtc)
  );

  // push on call or interrupt entry; interrupt also saves carry
  always_comb
  begin
    push = take_irq || (is_op && op_code == seq_pkg::OP_CALL);
    push_carry_en = take_irq;
    push_addr = take_irq ? pc : seq_pc;
  end

  // one shared entry for calls and interrupt entry
  return_stack u_stack
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(push),
    .push_addr(push_addr),
    .push_carry_en(push_carry_en),
    .push_carry(carry_in),
    .entry(stack_entry)
  );

  // next counter value; increment wraps in the 12-bit field
  always_comb
  begin
    seq_pc = step_of(pc, op_len_two);
    next_pc = seq_pc;
    if (is_op)
    begin
      unique case (op_code)
        seq_pkg::OP_JUMP, seq_pkg::OP_CALL:
          next_pc = target;
        seq_pkg::OP_BRANCH:
          if (branch_taken)
            next_pc = {pc[seq_pkg::MSB_BIT],
              target[seq_pkg::MSB_BIT-1:0]};
        seq_pkg::OP_RET, seq_pkg::OP_INTERRUPT_RETURN_OP:
          next_pc = stack_entry[seq_pkg::PC_W-1:0];
        default:
          next_pc = seq_pc;
      endcase
    end
  end

  // table address uses the already advanced counter's page, or LAST_PAGE for the fixed-page reads
  always_comb
  begin
    table_addr = {tread_last ? seq_pkg::LAST_PAGE :
      next_pc[seq_pkg::PC_W-1:seq_pkg::PAGE_W],
      pointer_high, pointer_low};
  end

  // bank value after this edge, so the fetch address follows a bank
  // write at the same edge as the bank bits themselves
  always_comb
  begin
    next_bank_hi = bank_wr ? bank_wdata[1] : rom_bank_sel_hi;
    next_bank_lo = bank_wr ? bank_wdata[0] : rom_bank_sel_lo;
  end

  // counter: reset, vectors, or decoded flow
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pc <= seq_pkg::RESET_VEC;
    else if (take_irq)
      pc <= take_rtc ? seq_pkg::RTC_VEC : seq_pkg::TIMER_VEC;
    else if (is_op)
      pc <= next_pc;
  end

  // bank select cleared at reset and never touched by flow changes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rom_bank_sel_lo <= seq_pkg::BANK_RESET[0];
      rom_bank_sel_hi <= seq_pkg::BANK_RESET[1];
    end
    else if (bank_wr)
    begin
      rom_bank_sel_lo <= bank_wdata[0];
      rom_bank_sel_hi <= bank_wdata[1];
    end
  end

  // in-call marker; interrupt entry counts as a call so a request held
  // across the service cannot overwrite the single stack entry
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      in_call <= 1'b0;
    else if (push)
      in_call <= 1'b1;
    else if (is_op && (op_code == seq_pkg::OP_RET ||
      op_code == seq_pkg::OP_INTERRUPT_RETURN_OP))
      in_call <= 1'b0;
  end

  // interrupt enable; reset leaves interrupts off and disable wins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ints_on <= 1'b0;
    else if (int_disable)
      ints_on <= 1'b0;
    else if (int_enable)
      ints_on <= 1'b1;
  end

  // state: a table read spends two extra cycles, table then wait, on the rom data
  always_comb
  begin
    next_state = state;
    unique case (state)
      seq_pkg::ST_FETCH:
        if (tread)
          next_state = seq_pkg::ST_TABLE;
      seq_pkg::ST_TABLE:
        next_state = seq_pkg::ST_WAIT;
      seq_pkg::ST_WAIT:
        next_state = seq_pkg::ST_FETCH;
      default:
        next_state = seq_pkg::ST_FETCH;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state <= seq_pkg::ST_FETCH;
    else
      state <= next_state;
  end

  // rom address: table location during a read, a vector on interrupt
  // entry, else the counter; refreshed every edge so a bank write or
  // the end of a table read puts the fetch address back on the counter
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rom_addr <= '0;
    else if (tread)
      rom_addr <= rom_of(next_bank_hi, next_bank_lo, table_addr);
    else if (take_irq)
      rom_addr <= rom_of(next_bank_hi, next_bank_lo,
        take_rtc ? seq_pkg::RTC_VEC : seq_pkg::TIMER_VEC);
    else
      rom_addr <= rom_of(next_bank_hi, next_bank_lo,
        is_op ? next_pc : pc);
  end

  // remember destination of a pending table read
  logic dest_mem;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      dest_mem <= 1'b0;
    else if (tread)
      dest_mem <= tread_mem;
  end

  // table result strobes one cycle when rom data returns; the byte for
  // the table address only stands on rom_data in the wait state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      table_byte <= '0;
      table_to_reg <= 1'b0;
      table_to_mem <= 1'b0;
    end
    else
    begin
      table_to_reg <= state == seq_pkg::ST_WAIT && !dest_mem;
      table_to_mem <= state == seq_pkg::ST_WAIT && dest_mem;
      if (state == seq_pkg::ST_WAIT)
        table_byte <= rom_data;
    end
  end

  // acknowledges are one-cycle pulses, shown with the vector load
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_ack <= 1'b0;
      rtc_ack <= 1'b0;
    end
    else
    begin
      timer_ack <= take_irq && take_timer;
      rtc_ack <= take_irq && take_rtc;
    end
  end

  // carry restore pulses on an interrupt return only; a plain return
  // leaves the core's carry alone, the saved bit is merely offered
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      carry_load <= 1'b0;
      carry_value <= 1'b0;
    end
    else
    begin
      carry_load <= is_op && op_code == seq_pkg::OP_INTERRUPT_RETURN_OP;
      carry_value <= stack_entry[seq_pkg::CARRY_BIT];
    end
  end

  // ready only in fetch so the decoder never overlaps a table read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      seq_ready <= 1'b0;
    else
      seq_ready <= next_state == seq_pkg::ST_FETCH;
  end
endmodule // program_sequencer

// File: verilog/return_stack.sv
// Purpose: one-level 13-bit return stack holding address and carry
// Assumes: pushes and pops come from the sequencer, never both at once
// Notes: a second push overwrites the saved entry
`timescale 1ns/1ps
module return_stack
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // push side
  input wire logic push,
  input wire logic [seq_pkg::PC_W-1:0] push_addr,
  input wire logic push_carry_en,
  input wire logic push_carry,
  // saved entry
  output logic [seq_pkg::STACK_W-1:0] entry
);
  // single entry; no depth check so an older return address is lost
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      entry <= '0;
    else if (push)
      entry <= {push_carry_en ? push_carry : 1'b0, push_addr};
  end
endmodule // return_stack

// File: verilog/seq_pkg.sv
// Purpose: shared constants for the program sequencer and its stack
// Assumes: nothing beyond plain SystemVerilog
// Notes: vectors, widths and operation codes used by the sequencer and return stack files
package seq_pkg;
  localparam int PC_W = 12;
  localparam int BANK_W = 2;
  localparam int ROM_ADDR_W = 14;
  localparam int PAGE_W = 8;
  localparam int STACK_W = 13;
  localparam logic [11:0] RESET_VEC = 12'h000;
  localparam logic [11:0] TIMER_VEC = 12'h004;
  localparam logic [11:0] RTC_VEC = 12'h008;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam int MSB_BIT = 11;
  localparam int CARRY_BIT = 12;
  // last page of a bank, used by the fixed-page table reads
  localparam logic [3:0] LAST_PAGE = 4'hF;
  // flow operations presented by the decoder, one per instruction
  typedef enum logic [3:0] {
    OP_SEQ = 4'h0,
    OP_JUMP = 4'h1,
    OP_CALL = 4'h2,
    OP_BRANCH = 4'h3,
    OP_RET = 4'h4,
    OP_INTERRUPT_RETURN_OP = 4'h5,
    OP_TREAD_REG = 4'h6,
    OP_TREAD_MEM = 4'h7,
    OP_TREAD_LAST_REG = 4'h8,
    OP_TREAD_LAST_MEM = 4'h9
  } flow_op_e;
  // fetch sequencer states
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_TABLE = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_e;
endpackage
